/* File: verilog/channel_measurement_sequencer.sv */
// Channel measurement sequencer: relays, switches, conditioning, A/D, frequency.
// Assumes ADC interrupt, deintegrate and frequency-ready pins are asynchronous;
// all other inputs come from logic on ref_clk.
//
// Overview of operation
// - Model A averages 1, 5/6 or 45/48 readings by rate and mains.
// - Model B averages 1, 4 or 20/24 readings by rate and mains.
// - Averaged readings run back to back with trigger held.
// - Averaging counts skip non-A/D measurements.
// - Relays only if changed, then switches, conditioning, then both settles.
// - DCV, VAC, ohms: trigger, average, store, then deselect.
// - Model B fast DCV runs continuous over same-class channel blocks.
// - Block: swap channel and write conditioning at deintegrate start.
// - Block: previous channel counters read during next autozero.
// - Thermocouple on 90 mV; optional open check gives marker value.
// - Scan with thermocouples starts with a reference junction reading.
// - Frequency starts with amplitude reading on highest AC range.
// - Frequency gain one step above AC choice, by amplitude.
// - Low amplitude still gets a frequency attempt.
// - Eight frequency readings averaged, no A/D.
// - Frequency ignores range field; rate changes settling and amplitude averaging.
// - Period overflow gives 0 Hz; frequency overflow gives overload.
// - No frequency ready within 500 ms gives 0 Hz.
// - After AC or frequency: discharge relays, drain high 6 ms.
// - Autorange starts on last range or highest; steps up or down.
// - Medium and slow rates decide range on first reading only.
// - Each autoranging channel moves one direction per scan.
// - A/D mode by two-bit command latched on strobe rising edge.
// - Counters read on interrupt fall, within autozero.
`timescale 1ns/10ps
module channel_measurement_sequencer #(
	parameter int CH_W = 6,
	parameter int SETTLE_MED_CYC = seq_pkg::SETTLE_MED_CYC,
	parameter int SETTLE_SLOW_CYC = seq_pkg::SETTLE_SLOW_CYC,
	parameter int DRAIN_CYC = seq_pkg::DRAIN_CYC,
	parameter int FREQ_TMO_CYC = seq_pkg::FREQ_TMO_CYC,
	parameter int OVR_LIM = seq_pkg::OVR_LIM_DEF,
	parameter int UNDR_LIM = seq_pkg::UNDR_LIM_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] rate,
	input wire logic mains_50hz,
	input wire logic model_b,
	input wire logic scan_start,
	input wire logic scan_has_tc,
	input wire logic ch_valid,
	output logic ch_ready,
	input wire logic [CH_W-1:0] ch_id,
	input wire logic [2:0] ch_func,
	input wire logic [2:0] ch_range,
	input wire logic ch_autorange,
	input wire logic ch_otc_en,
	input wire logic ch_last,
	output logic adc_trigger,
	output logic [1:0] adc_cmd,
	output logic adc_cmd_stb,
	input wire logic adc_int_n,
	input wire logic adc_deint_n,
	output logic cnt_rd_req,
	input wire logic cnt_rd_done,
	input wire logic [23:0] cnt_value,
	output logic cond_wr,
	output logic [7:0] cond_cfg,
	output logic freq_start,
	input wire logic frequency_result_ready,
	input wire logic [23:0] freq_value,
	input wire logic period_overflow_flag,
	input wire logic frequency_overflow_flag,
	output logic relay_set,
	output logic [2:0] relay_pos,
	input wire logic relay_done,
	output logic sw_sel,
	output logic [CH_W-1:0] sw_chan,
	output logic otc_check,
	input wire logic otc_done,
	input wire logic otc_open,
	output logic drain,
	output logic res_valid,
	input wire logic res_ready,
	output logic [31:0] res_data,
	output logic [CH_W-1:0] res_ch,
	output logic [2:0] res_rng,
	output logic [5:0] res_nrd,
	output logic res_rj,
	output logic busy
);
	localparam int NCH = 1 << CH_W;

	if (CH_W < 1 || CH_W > 8 || FREQ_TMO_CYC >= 2**24 || DRAIN_CYC >= 2**24 ||
		SETTLE_SLOW_CYC >= 2**24 || SETTLE_MED_CYC >= 2**24 || DRAIN_CYC < 1) begin : g_bad
		$error("channel_measurement_sequencer: parameter out of range");
	end

	typedef enum logic [16:0] {
		S_IDLE = 17'h00001, S_FETCH = 17'h00002, S_RELAY = 17'h00004, S_RLYW = 17'h00008,
		S_SWSEL = 17'h00010, S_COND = 17'h00020, S_SETTLE = 17'h00040, S_CMD = 17'h00080,
		S_STB = 17'h00100, S_ARM = 17'h00200, S_TRIG = 17'h00400, S_READ = 17'h00800,
		S_OTC = 17'h01000, S_STORE = 17'h02000, S_DESEL = 17'h04000, S_DRAIN = 17'h08000,
		S_FREQ = 17'h10000
	} st_e;

	typedef struct packed {
		st_e st;
		logic [1:0] s_int;
		logic [1:0] s_de;
		logic [1:0] s_fr;
		logic int_d;
		logic de_d;
		logic fr_d;
		logic [CH_W-1:0] ch;
		logic [CH_W-1:0] pch;
		logic [2:0] func;
		logic [2:0] rng;
		logic [2:0] prng;
		logic autor;
		logic otce;
		logic last;
		logic pend;
		logic rr;
		logic up;
		logic dn;
		logic rj;
		logic fph;
		logic phase;
		logic [23:0] tmr;
		logic [5:0] nrd;
		logic [3:0] nf;
		logic [31:0] sum;
		logic [31:0] rdata;
		logic [CH_W-1:0] rch;
		logic [2:0] rrng;
		logic [5:0] rnrd;
		logic rrj;
		logic trig;
		logic [1:0] cmd;
		logic stb;
		logic rdq;
		logic cwr;
		logic [7:0] ccfg;
		logic fst;
		logic rly;
		logic [2:0] rpos;
		logic ssel;
		logic [CH_W-1:0] sch;
		logic otcg;
		logic drn;
	} st_s;

	st_s r, n;
	logic [3:0] rmem [NCH];
	logic mem_we;
	logic blk_take;
	logic [5:0] n_avg;
	logic [31:0] val;
	logic [31:0] absv;
	logic [31:0] fsum;
	logic [2:0] want;
	logic [2:0] maxr;
	logic [2:0] start_rng;
	logic [23:0] settle_cyc;
	logic int_fall;
	logic de_fall;
	logic fr_rise;
	logic blk_mode;
	logic blk_go;
	logic done_rd;

	avg_count_sel u_avg (
		.rate(rate),
		.mains_50hz(mains_50hz),
		.model_b(model_b),
		.exempt(r.fph),
		.n_avg(n_avg)
	);

	assign val = {{8{cnt_value[23]}}, cnt_value};
	assign absv = val[31] ? 32'(-val) : val;
	assign fsum = r.sum + {8'h00, freq_value};
	assign int_fall = r.int_d & ~r.s_int[1];
	assign de_fall = r.de_d & ~r.s_de[1];
	assign fr_rise = ~r.fr_d & r.s_fr[1];
	assign done_rd = ({2'h0, r.nrd} + 8'h01) >= {2'h0, n_avg};
	// Continuous triggering needs no relay or autorange changes
	assign blk_mode = model_b && rate == seq_pkg::RATE_FAST && r.func == seq_pkg::FN_DCV &&
		!r.autor && !r.rj;
	assign blk_go = blk_mode && ch_valid && !r.last && ch_func == seq_pkg::FN_DCV && !ch_autorange &&
		((ch_range >= seq_pkg::DCV_HIGH_FIRST) == (r.rng >= seq_pkg::DCV_HIGH_FIRST));
	assign ch_ready = (r.st == S_FETCH) | blk_take;

	always_comb begin
		case (r.func)
			seq_pkg::FN_VAC, seq_pkg::FN_FREQ: maxr = seq_pkg::RNG_MAX_VAC;
			seq_pkg::FN_OHM: maxr = seq_pkg::RNG_MAX_OHM;
			default: maxr = seq_pkg::top_voltage_range;
		endcase
		case (r.func)
			seq_pkg::FN_TC: want = seq_pkg::FN_DCV;
			seq_pkg::FN_FREQ: want = seq_pkg::FN_VAC;
			default: want = r.func;
		endcase
		case (rate)
			seq_pkg::RATE_MED: settle_cyc = 24'(SETTLE_MED_CYC);
			seq_pkg::RATE_SLOW: settle_cyc = 24'(SETTLE_SLOW_CYC);
			default: settle_cyc = 24'(seq_pkg::SETTLE_FAST_CYC);
		endcase
		if (ch_func == seq_pkg::FN_FREQ) begin
			start_rng = seq_pkg::RNG_MAX_VAC;
		end else if (ch_func == seq_pkg::FN_TC) begin
			start_rng = seq_pkg::DCV_90MV;
		end else if (ch_autorange) begin
			if (rmem[ch_id][3]) begin
				start_rng = rmem[ch_id][2:0];
			end else if (ch_func == seq_pkg::FN_VAC) begin
				start_rng = seq_pkg::RNG_MAX_VAC;
			end else if (ch_func == seq_pkg::FN_OHM) begin
				start_rng = seq_pkg::RNG_MAX_OHM;
			end else begin
				start_rng = seq_pkg::top_voltage_range;
			end
		end else begin
			start_rng = ch_range;
		end
	end

	always_comb begin
		n = r;
		mem_we = 1'b0;
		blk_take = 1'b0;
		// Synchronisers: first stage feeds only the second
		n.s_int = {r.s_int[0], adc_int_n};
		n.s_de = {r.s_de[0], adc_deint_n};
		n.s_fr = {r.s_fr[0], frequency_result_ready};
		n.int_d = r.s_int[1];
		n.de_d = r.s_de[1];
		n.fr_d = r.s_fr[1];
		n.stb = 1'b0;
		n.rdq = 1'b0;
		n.cwr = 1'b0;
		n.fst = 1'b0;
		n.rly = 1'b0;
		n.otcg = 1'b0;
		if (r.tmr != 24'h0) begin
			n.tmr = r.tmr - 24'h1;
		end
		case (r.st)
			S_IDLE: begin
				if (scan_start) begin
					n.fph = 1'b0;
					if (scan_has_tc) begin
						n.rj = 1'b1;
						n.func = seq_pkg::FN_DCV;
						n.rng = seq_pkg::DCV_90MV;
						n.autor = 1'b0;
						n.last = 1'b0;
						n.st = S_COND;
					end else begin
						n.st = S_FETCH;
					end
				end
			end
			S_FETCH: begin
				if (ch_valid) begin
					n.ch = ch_id;
					n.func = ch_func;
					n.rng = start_rng;
					n.autor = ch_autorange && ch_func != seq_pkg::FN_FREQ && ch_func != seq_pkg::FN_TC;
					n.otce = ch_otc_en;
					n.last = ch_last;
					n.up = 1'b0;
					n.dn = 1'b0;
					n.fph = 1'b0;
					n.st = S_RELAY;
				end
			end
			S_RELAY: begin
				if (r.rpos != want) begin
					n.rpos = want;
					n.rly = 1'b1;
					n.st = S_RLYW;
				end else begin
					n.st = S_SWSEL;
				end
			end
			S_RLYW: if (relay_done) n.st = S_SWSEL;
			S_SWSEL: begin
				n.ssel = 1'b1;
				n.sch = r.ch;
				n.st = S_COND;
			end
			S_COND: begin
				n.ccfg = {r.fph, r.rj, r.func, r.rng};
				n.cwr = 1'b1;
				n.tmr = 24'(seq_pkg::SW_SETTLE_CYC);
				n.phase = 1'b0;
				n.st = S_SETTLE;
			end
			S_SETTLE: begin
				if (r.tmr == 24'h0) begin
					if (!r.phase) begin
						n.phase = 1'b1;
						n.tmr = settle_cyc;
					end else if (r.fph) begin
						n.fst = 1'b1;
						n.tmr = 24'(FREQ_TMO_CYC);
						n.nf = 4'h0;
						n.sum = 32'h0;
						n.st = S_FREQ;
					end else begin
						n.st = S_CMD;
					end
				end
			end
			S_CMD: begin
				n.cmd = seq_pkg::ADC_MEASURE;
				n.st = S_STB;
			end
			S_STB: begin
				n.stb = 1'b1;
				n.nrd = 6'h0;
				n.sum = 32'h0;
				n.rr = 1'b0;
				n.st = S_ARM;
			end
			S_ARM: begin
				n.trig = 1'b1;
				n.st = S_TRIG;
			end
			S_TRIG: begin
				if (de_fall && r.trig && !r.rr) begin
					if (blk_go) begin
						blk_take = 1'b1;
						n.pend = 1'b1;
						n.pch = r.ch;
						n.prng = r.rng;
						n.ch = ch_id;
						n.rng = ch_range;
						n.last = ch_last;
						n.sch = ch_id;
						n.ccfg = {2'h0, seq_pkg::FN_DCV, ch_range};
						n.cwr = 1'b1;
					end else if (done_rd) begin
						n.trig = 1'b0;
					end
				end
				if (int_fall) begin
					if (r.rr) begin
						n.st = S_COND;
					end else begin
						n.rdq = 1'b1;
						n.st = S_READ;
					end
				end
			end
			S_READ: begin
				if (cnt_rd_done) begin
					if (r.pend) begin
						n.pend = 1'b0;
						n.rdata = val;
						n.rch = r.pch;
						n.rrng = r.prng;
						n.rnrd = 6'h01;
						n.rrj = 1'b0;
						n.st = S_STORE;
					end else if (r.nrd == 6'h0 && r.autor && absv > 32'(OVR_LIM) && !r.dn && r.rng < maxr) begin
						n.rng = r.rng + 3'h1;
						n.up = 1'b1;
						n.trig = 1'b0;
						n.rr = !done_rd;
						n.st = done_rd ? S_COND : S_TRIG;
					end else if (r.nrd == 6'h0 && r.autor && absv < 32'(UNDR_LIM) && !r.up &&
						r.rng != 3'h0) begin
						n.rng = r.rng - 3'h1;
						n.dn = 1'b1;
						n.trig = 1'b0;
						n.rr = !done_rd;
						n.st = done_rd ? S_COND : S_TRIG;
					end else begin
						n.sum = r.sum + val;
						n.nrd = r.nrd + 6'h01;
						if (!done_rd) begin
							n.st = S_TRIG;
						end else if (r.func == seq_pkg::FN_FREQ) begin
							// Amplitude reading only picks the gain; never stored
							if (absv < seq_pkg::AMP_3V_CNT) begin
								n.rng = seq_pkg::ac_gain_range_low;
							end else if (absv < seq_pkg::AMP_30V_CNT || model_b) begin
								n.rng = seq_pkg::ac_gain_range_mid;
							end else begin
								n.rng = seq_pkg::ac_gain_range_high;
							end
							n.fph = 1'b1;
							n.st = S_DESEL;
						end else begin
							n.rdata = r.sum + val;
							n.rch = r.ch;
							n.rrng = r.rng;
							n.rnrd = r.nrd + 6'h01;
							n.rrj = r.rj;
							n.otcg = r.func == seq_pkg::FN_TC && r.otce;
							n.st = (r.func == seq_pkg::FN_TC && r.otce) ? S_OTC : S_STORE;
						end
					end
				end
			end
			S_OTC: begin
				if (otc_done) begin
					if (otc_open) n.rdata = seq_pkg::open_input_marker_value;
					n.st = S_STORE;
				end
			end
			S_STORE: begin
				if (res_ready) begin
					mem_we = r.autor && !r.rrj;
					if (r.trig) begin
						n.st = S_TRIG;
					end else if (r.rj) begin
						n.rj = 1'b0;
						n.st = S_FETCH;
					end else begin
						n.st = S_DESEL;
					end
				end
			end
			S_DESEL: begin
				n.ssel = 1'b0;
				if (r.func == seq_pkg::FN_VAC || r.func == seq_pkg::FN_FREQ) begin
					n.rpos = seq_pkg::RLY_DISCHARGE;
					n.rly = 1'b1;
					n.drn = 1'b1;
					n.tmr = 24'(DRAIN_CYC);
					n.st = S_DRAIN;
				end else begin
					n.st = r.last ? S_IDLE : S_FETCH;
				end
			end
			S_DRAIN: begin
				if (r.tmr == 24'h0) begin
					n.drn = 1'b0;
					if (r.func == seq_pkg::FN_FREQ && r.fph) begin
						n.st = S_RELAY;
					end else begin
						n.st = r.last ? S_IDLE : S_FETCH;
					end
				end
			end
			S_FREQ: begin
				n.rch = r.ch;
				n.rrng = r.rng;
				n.rrj = 1'b0;
				if (fr_rise) begin
					n.sum = fsum;
					n.nf = r.nf + 4'h1;
					if (r.nf == seq_pkg::FREQ_READS - 4'h1) begin
						if (period_overflow_flag) begin
							n.rdata = seq_pkg::ZERO_HZ;
						end else if (frequency_overflow_flag) begin
							n.rdata = seq_pkg::positive_overload_value;
						end else begin
							n.rdata = {3'h0, fsum[31:3]};
						end
						n.rnrd = {2'h0, seq_pkg::FREQ_READS};
						n.fph = 1'b0;
						n.st = S_STORE;
					end else begin
						n.fst = 1'b1;
					end
				end else if (r.tmr == 24'h0) begin
					n.rdata = seq_pkg::ZERO_HZ;
					n.rnrd = 6'h0;
					n.fph = 1'b0;
					n.st = S_STORE;
				end
			end
			default: n.st = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= S_IDLE;
			r.s_int <= 2'h3;
			r.s_de <= 2'h3;
			r.int_d <= 1'b1;
			r.de_d <= 1'b1;
			r.cmd <= seq_pkg::ADC_MEASURE;
		end else begin
			r <= n;
		end
	end

	// Range history survives between scans; cleared only by reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) rmem[i] <= 4'h0;
		end else if (mem_we) begin
			rmem[r.rch] <= {1'b1, r.rrng};
		end
	end

	assign adc_trigger = r.trig;
	assign adc_cmd = r.cmd;
	assign adc_cmd_stb = r.stb;
	assign cnt_rd_req = r.rdq;
	assign cond_wr = r.cwr;
	assign cond_cfg = r.ccfg;
	assign freq_start = r.fst;
	assign relay_set = r.rly;
	assign relay_pos = r.rpos;
	assign sw_sel = r.ssel;
	assign sw_chan = r.sch;
	assign otc_check = r.otcg;
	assign drain = r.drn;
	assign res_valid = r.st == S_STORE;
	assign res_data = r.rdata;
	assign res_ch = r.rch;
	assign res_rng = r.rrng;
	assign res_nrd = r.rnrd;
	assign res_rj = r.rrj;
	assign busy = r.st != S_IDLE;
endmodule : channel_measurement_sequencer

/* File: verilog/seq_pkg.sv */
// Constants shared by the channel measurement sequencer and its helpers.
// Assumes a 20 MHz ref_clk; cycle counts are derived from it here.
package seq_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;

	// Reading rate codes
	localparam logic [1:0] RATE_FAST = 2'h0;
	localparam logic [1:0] RATE_MED = 2'h1;
	localparam logic [1:0] RATE_SLOW = 2'h2;

	// Channel function codes
	localparam logic [2:0] FN_DCV = 3'h0;
	localparam logic [2:0] FN_VAC = 3'h1;
	localparam logic [2:0] FN_OHM = 3'h2;
	localparam logic [2:0] FN_TC = 3'h3;
	localparam logic [2:0] FN_FREQ = 3'h4;
	localparam logic [2:0] RLY_DISCHARGE = 3'h7;

	// A/D command codes
	localparam logic [1:0] ADC_MEASURE = 2'h0;
	localparam logic [1:0] ADC_REFBAL_ON = 2'h1;
	localparam logic [1:0] ADC_REFBAL_OFF = 2'h2;

	// Readings averaged per measurement
	localparam logic [5:0] AVG_FAST = 6'h01;
	localparam logic [5:0] AVG_A_MED_60 = 6'h05;
	localparam logic [5:0] AVG_A_MED_50 = 6'h06;
	localparam logic [5:0] AVG_A_SLOW_60 = 6'h2D;
	localparam logic [5:0] AVG_A_SLOW_50 = 6'h30;
	localparam logic [5:0] AVG_B_MED = 6'h04;
	localparam logic [5:0] AVG_B_SLOW_60 = 6'h14;
	localparam logic [5:0] AVG_B_SLOW_50 = 6'h18;
	localparam logic [3:0] FREQ_READS = 4'h8;

	// Range codes
	localparam logic [2:0] DCV_90MV = 3'h0;
	localparam logic [2:0] DCV_HIGH_FIRST = 3'h4;
	localparam logic [2:0] top_voltage_range = 3'h5;
	localparam logic [2:0] RNG_MAX_VAC = 3'h3;
	localparam logic [2:0] RNG_MAX_OHM = 3'h5;
	localparam logic [2:0] ac_gain_range_low = 3'h0;
	localparam logic [2:0] ac_gain_range_mid = 3'h1;
	localparam logic [2:0] ac_gain_range_high = 3'h2;

	// Amplitude thresholds on the highest AC range and autorange limits, raw counts
	localparam logic [31:0] AMP_3V_CNT = 32'h0000_1000;
	localparam logic [31:0] AMP_30V_CNT = 32'h0000_A000;
	localparam int OVR_LIM_DEF = 32'h0007_0000;
	localparam int UNDR_LIM_DEF = 32'h0000_6000;

	// Result codes
	localparam logic [31:0] open_input_marker_value = 32'h7FFF_FFFE;
	localparam logic [31:0] positive_overload_value = 32'h7FFF_FFFF;
	localparam logic [31:0] ZERO_HZ = 32'h0000_0000;

	// Times and derived cycle counts
	localparam int SW_SETTLE_US = 30;
	localparam int SETTLE_FAST_US = 30;
	localparam int SETTLE_MED_US = 1000;
	localparam int SETTLE_SLOW_US = 10000;
	localparam int DRAIN_MS = 6;
	localparam int FREQ_TMO_MS = 500;
	localparam int SW_SETTLE_CYC = SW_SETTLE_US * CYC_PER_US;
	localparam int SETTLE_FAST_CYC = SETTLE_FAST_US * CYC_PER_US;
	localparam int SETTLE_MED_CYC = SETTLE_MED_US * CYC_PER_US;
	localparam int SETTLE_SLOW_CYC = SETTLE_SLOW_US * CYC_PER_US;
	localparam int DRAIN_CYC = DRAIN_MS * CYC_PER_MS;
	localparam int FREQ_TMO_CYC = FREQ_TMO_MS * CYC_PER_MS;
endpackage : seq_pkg

/* File: verilog/avg_count_sel.sv */
// Readings-per-measurement selector.
// Assumes static rate, mains and model inputs from the same clock domain.
`timescale 1ns/10ps
module avg_count_sel (
	input wire logic [1:0] rate,
	input wire logic mains_50hz,
	input wire logic model_b,
	input wire logic exempt,
	output logic [5:0] n_avg
);
	always_comb begin
		n_avg = seq_pkg::AVG_FAST;
		if (exempt) begin
			n_avg = seq_pkg::AVG_FAST;
		end else if (!model_b) begin
			case (rate)
				seq_pkg::RATE_MED: n_avg = mains_50hz ? seq_pkg::AVG_A_MED_50 : seq_pkg::AVG_A_MED_60;
				seq_pkg::RATE_SLOW: n_avg = mains_50hz ? seq_pkg::AVG_A_SLOW_50 : seq_pkg::AVG_A_SLOW_60;
				default: n_avg = seq_pkg::AVG_FAST;
			endcase
		end else begin
			case (rate)
				seq_pkg::RATE_MED: n_avg = seq_pkg::AVG_B_MED;
				seq_pkg::RATE_SLOW: n_avg = mains_50hz ? seq_pkg::AVG_B_SLOW_50 : seq_pkg::AVG_B_SLOW_60;
				default: n_avg = seq_pkg::AVG_FAST;
			endcase
		end
	end
endmodule : avg_count_sel

/* File: bench/cms_props.sv */
// Port checker for the channel measurement sequencer.
// Assumes one ref_clk domain; bound to every sequencer instance.
`timescale 1ns/10ps
module cms_props #(
	parameter int DRAIN_CYC = seq_pkg::DRAIN_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] adc_cmd,
	input wire logic adc_cmd_stb,
	input wire logic adc_trigger,
	input wire logic adc_int_n,
	input wire logic cnt_rd_req,
	input wire logic relay_set,
	input wire logic [2:0] relay_pos,
	input wire logic sw_sel,
	input wire logic freq_start,
	input wire logic drain,
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic [31:0] res_data,
	input wire logic res_rj
);
	logic [23:0] drain_cnt_r;
	logic [15:0] sel_cnt_r;
	// Saturates, so a long selection never wraps into an early trigger
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drain_cnt_r <= 24'h000000;
			sel_cnt_r <= 16'h0000;
		end else begin
			drain_cnt_r <= drain ? drain_cnt_r + 24'h000001 : 24'h000000;
			sel_cnt_r <= !sw_sel ? 16'h0000 : sel_cnt_r + {15'h0000, ~&sel_cnt_r};
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_cmd; adc_cmd_stb |-> (adc_cmd == seq_pkg::ADC_MEASURE && !adc_trigger) ##1 !adc_cmd_stb; endproperty
	a_cmd: assert property (p_cmd) else $error("bad command strobe");
	property p_trig; $rose(adc_trigger) |-> $past(adc_cmd_stb); endproperty
	a_trig: assert property (p_trig) else $error("trigger without command");
	property p_settle; $rose(adc_trigger) && sw_sel |-> sel_cnt_r >= 16'(seq_pkg::SW_SETTLE_CYC); endproperty
	a_settle: assert property (p_settle) else $error("trigger before switch settle");
	property p_rd_az; cnt_rd_req |-> !adc_int_n; endproperty
	a_rd_az: assert property (p_rd_az) else $error("counter read outside autozero");
	property p_relay; relay_set |-> !adc_trigger; endproperty
	a_relay: assert property (p_relay) else $error("relay moved while triggered");
	property p_fstart; freq_start |-> !adc_trigger; endproperty
	a_fstart: assert property (p_fstart) else $error("frequency read with A/D running");
	property p_drain; $fell(drain) |-> drain_cnt_r >= DRAIN_CYC && drain_cnt_r <= DRAIN_CYC + 1; endproperty
	a_drain: assert property (p_drain) else $error("drain width wrong");
	property p_dpos; drain && $past(drain, 2) |-> relay_pos == seq_pkg::RLY_DISCHARGE; endproperty
	a_dpos: assert property (p_dpos) else $error("relays not at discharge");
	property p_hold; res_valid && !res_ready |=> res_valid && $stable(res_data) && $stable(res_rj); endproperty
	a_hold: assert property (p_hold) else $error("result changed while waiting");
	property p_drop; res_valid && res_ready |=> !res_valid; endproperty
	a_drop: assert property (p_drop) else $error("result not retired");
	c_rj: cover property (res_valid && res_ready && res_rj);
	c_drain: cover property ($fell(drain));
	c_freq: cover property (freq_start);
endmodule : cms_props
bind channel_measurement_sequencer cms_props #(.DRAIN_CYC(DRAIN_CYC)) u_cms_props (.*);

/* File: bench/adc_side_model.sv */
// Far side: A/D state machine, frequency counter, relays, open check.
// Assumes the bench sets cnt_set, fmode and open_set between scans.
`timescale 1ns/10ps
module adc_side_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic adc_trigger,
	output logic adc_int_n,
	output logic adc_deint_n,
	input wire logic cnt_rd_req,
	output logic cnt_rd_done,
	output logic [23:0] cnt_value,
	input wire logic [23:0] cnt_set,
	input wire logic freq_start,
	output logic frequency_result_ready,
	output logic [23:0] freq_value,
	output logic period_overflow_flag,
	output logic frequency_overflow_flag,
	input wire logic [1:0] fmode,
	input wire logic relay_set,
	output logic relay_done,
	input wire logic otc_check,
	output logic otc_done,
	output logic otc_open,
	input wire logic open_set
);
	int ph;
	int fc;
	logic [2:0] rd_d;
	logic [2:0] rl_d;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph <= 0;
			fc <= 0;
			rd_d <= 3'h0;
			rl_d <= 3'h0;
			adc_int_n <= 1'b1;
			adc_deint_n <= 1'b1;
			cnt_rd_done <= 1'b0;
			cnt_value <= 24'h000000;
			frequency_result_ready <= 1'b0;
			freq_value <= 24'h000000;
			period_overflow_flag <= 1'b0;
			frequency_overflow_flag <= 1'b0;
			relay_done <= 1'b0;
			otc_done <= 1'b0;
			otc_open <= 1'b0;
		end else begin
			// Autozero 0-9, integrate 10-19, deintegrate 20-28; held trigger chains
			if (ph != 0 || adc_trigger) ph <= (ph == 29) ? 0 : ph + 1;
			adc_int_n <= (ph == 10) ? 1'b1 : (ph == 29) ? 1'b0 : adc_int_n;
			adc_deint_n <= !(ph >= 20 && ph < 29);
			rd_d <= {rd_d[1:0], cnt_rd_req};
			cnt_rd_done <= rd_d[1];
			// Counters clear at integrate, so a late read sees zero
			cnt_value <= rd_d[1] ? (adc_int_n ? 24'h000000 : cnt_set) : ~cnt_value;
			// Mode 3 never answers
			fc <= (freq_start && fmode != 2'h3) ? 1 : (fc == 0 || fc == 20) ? 0 : fc + 1;
			frequency_result_ready <= fc >= 10;
			freq_value <= fc >= 10 ? 24'h001234 : ~freq_value;
			period_overflow_flag <= fc >= 10 ? fmode == 2'h1 : !period_overflow_flag;
			frequency_overflow_flag <= fc >= 10 ? fmode == 2'h2 : !frequency_overflow_flag;
			rl_d <= {rl_d[1:0], relay_set};
			relay_done <= rl_d[2];
			otc_done <= otc_check;
			otc_open <= otc_check ? open_set : !otc_open;
		end
	end
endmodule : adc_side_model

/* File: bench/channel_measurement_sequencer_bench.sv */
// Self-checking bench: sequencer, far-side model, queue model of results.
// Assumes the checker binds itself to the sequencer.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module channel_measurement_sequencer_bench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] rate = 2'h0;
	logic mains_50hz = 1'b0;
	logic model_b = 1'b0;
	logic scan_start = 1'b0;
	logic scan_has_tc = 1'b0;
	logic ch_valid = 1'b0;
	logic [5:0] ch_id = 6'h00;
	logic [2:0] ch_func = 3'h0;
	logic [2:0] ch_range = 3'h0;
	logic ch_autorange = 1'b0;
	logic ch_otc_en = 1'b0;
	logic ch_last = 1'b0;
	logic res_ready = 1'b0;
	logic [23:0] cnt_set = 24'h010000;
	logic [1:0] fmode = 2'h0;
	logic open_set = 1'b0;
	logic ch_ready, adc_trigger, adc_cmd_stb, adc_int_n, adc_deint_n, cnt_rd_req, cnt_rd_done, cond_wr, freq_start;
	logic frequency_result_ready, period_overflow_flag, frequency_overflow_flag, relay_set, relay_done, sw_sel;
	logic otc_check, otc_done, otc_open, drain, res_valid, res_rj, busy;
	logic [1:0] adc_cmd;
	logic [2:0] relay_pos, res_rng;
	logic [5:0] sw_chan, res_ch, res_nrd;
	logic [7:0] cond_cfg;
	logic [23:0] cnt_value, freq_value;
	logic [31:0] res_data;
	int fails = 0;
	int checked = 0;
	int seed = 55697;
	int fexp[4] = '{32'h0000_1234, 0, 32'h7FFF_FFFF, 0};
	int ed[$];
	int en[$];
	logic er[$];
	int i, n, rn, rd, re;
	channel_measurement_sequencer #(.SETTLE_MED_CYC(10), .SETTLE_SLOW_CYC(10), .DRAIN_CYC(20), .FREQ_TMO_CYC(200))
		u_channel_measurement_sequencer (.*);
	adc_side_model u_adc_side_model (.*);
	always #25 ref_clk = ~ref_clk;
	// Random stalls on the result side
	always @(negedge ref_clk) begin
		res_ready = 1'($random(seed));
		if (rst_n && res_valid === 1'b1 && res_ready) begin
			`CHK(ed.size() != 0, 1'b1)
			if (ed.size() != 0) begin
				rn = en.pop_front();
				rd = ed.pop_front();
				`CHK(res_data, rd)
				re = er.pop_front();
				`CHK(res_rj, re[0])
				if (rn >= 0) `CHK(res_nrd, rn[5:0])
			end
		end
	end
	task automatic test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	function automatic int navg();
		if (rate == 2'h0) return 1;
		if (model_b) return rate == 2'h1 ? 4 : (mains_50hz ? 24 : 20);
		return rate == 2'h1 ? (mains_50hz ? 6 : 5) : (mains_50hz ? 48 : 45);
	endfunction : navg
	task automatic scan(input logic tc);
		cnt_set = {9'h001, 15'($random(seed))};
		n = navg();
		scan_has_tc = tc;
		scan_start = 1'b1;
		if (tc) begin
			ed.push_back(n * int'(cnt_set));
			en.push_back(n);
			er.push_back(1'b1);
		end
		@(negedge ref_clk);
		scan_start = 1'b0;
	endtask : scan
	task automatic send(input logic [2:0] f, input logic [2:0] rg, input logic oe, input logic last, input int d,
		input int nr);
		int k;
		ch_id = ch_id + 6'h01;
		ch_func = f;
		ch_range = rg;
		ch_otc_en = oe;
		ch_last = last;
		ch_valid = 1'b1;
		ed.push_back(d);
		en.push_back(nr);
		er.push_back(1'b0);
		#1;
		for (k = 0; k < 9000 && ch_ready !== 1'b1; k++) begin
			@(negedge ref_clk);
			#1;
		end
		if (k == 9000) begin
			fails++;
			test_done();
		end
		@(negedge ref_clk);
	endtask : send
	task automatic end_scan(input int t);
		int k;
		ch_valid = 1'b0;
		for (k = 0; k < 9000 && (ed.size() != 0 || busy !== 1'b0); k++) @(negedge ref_clk);
		if (k == 9000) begin
			fails++;
			test_done();
		end
		$display("test %0d ended", t);
	endtask : end_scan
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		for (i = 0; i < 12; i++) begin
			rate = 2'(i % 3);
			mains_50hz = 1'((i / 3) % 2);
			model_b = 1'(i / 6);
			scan(1'b0);
			send(seq_pkg::FN_DCV, 3'h1, 1'b0, 1'b1, n * int'(cnt_set), n);
			end_scan(i);
		end
		// Continuous low-range block
		rate = seq_pkg::RATE_FAST;
		scan(1'b0);
		for (i = 0; i < 3; i++) send(seq_pkg::FN_DCV, 3'(i), 1'b0, 1'(i == 2), int'(cnt_set), 1);
		end_scan(12);
		model_b = 1'b0;
		rate = seq_pkg::RATE_MED;
		open_set = 1'($random(seed));
		scan(1'b1);
		send(seq_pkg::FN_TC, 3'h0, 1'b1, 1'b0,
			open_set ? seq_pkg::open_input_marker_value : n * int'(cnt_set), -1);
		send(seq_pkg::FN_TC, 3'h0, 1'b0, 1'b1, n * int'(cnt_set), n);
		end_scan(13);
		rate = seq_pkg::RATE_FAST;
		for (i = 0; i < 4; i++) begin
			fmode = 2'(i);
			scan(1'b0);
			ch_autorange = 1'(i == 0);
			// Small counts walk the autorange channel down
			if (i == 0) cnt_set[23:13] = 11'h000;
			send(seq_pkg::FN_DCV, 3'h5, 1'b0, 1'b0, int'(cnt_set), 1);
			ch_autorange = 1'b0;
			send(seq_pkg::FN_VAC, 3'h2, 1'b0, 1'b0, int'(cnt_set), 1);
			send(seq_pkg::FN_OHM, 3'h3, 1'b0, 1'b0, int'(cnt_set), 1);
			send(seq_pkg::FN_FREQ, 3'($random(seed)), 1'b0, 1'b1, fexp[i], -1);
			end_scan(14 + i);
		end
		test_done();
	end
endmodule : channel_measurement_sequencer_bench
